// file: common/tdt_defines.svh
`ifndef TDT_DEFINES_SVH
`define TDT_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define TDT_OFF_CTRL      8'h00
`define TDT_OFF_MODE      8'h04
`define TDT_OFF_TIMER_CONTROL_REG      8'h08
`define TDT_OFF_CNT_BASE  8'h10

// ------------------------------------------------------------
// counter byte indices
// ------------------------------------------------------------
`define TDT_IDX_L0        2'h0
`define TDT_IDX_H0        2'h1
`define TDT_IDX_L1        2'h2
`define TDT_IDX_H1        2'h3

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TDT_CTRL_EN       0
`define TDT_CTRL_XEN      1
`define TDT_CTRL_SEL0     4:2
`define TDT_CTRL_SEL1     7:5
`define TDT_MODE_FLD      2:0
`define TDT_MODE_DIV      6:4
`define TDT_TIMER_CONTROL_REG_RUN0     0
`define TDT_TIMER_CONTROL_REG_FULL0    1
`define TDT_TIMER_CONTROL_REG_RUN1     2
`define TDT_TIMER_CONTROL_REG_FULL1    3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TDT_RST_BYTE      8'h00
`define TDT_RST_FLD       3'h0

// ------------------------------------------------------------
// mode codes
// ------------------------------------------------------------
`define TDT_MODE_0        3'h0
`define TDT_MODE_1        3'h1
`define TDT_MODE_2        3'h2
`define TDT_MODE_3        3'h3
`define TDT_MODE_4        3'h4
`define TDT_MODE_5        3'h5
`define TDT_MODE_6        3'h6
`define TDT_MODE_7        3'h7

// ------------------------------------------------------------
// count clock division ratios
// ------------------------------------------------------------
`define TDT_RC_DIV8       8
`define TDT_RC_DIV32      32
`define TDT_RC_DIV128     128
`define TDT_RC_DIV512     512
`define TDT_XT_DIV6       6
`define TDT_XT_DIV512     512
`define TDT_R90_DIV8      8

`endif

// file: common/tdt_pkg.sv
package tdt_pkg;

    // one decrement step of a counter
    typedef struct packed {
        logic        uf;
        logic [15:0] val;
    } tdt_step_t;

    // run bits and full flags
    typedef struct packed {
        logic full1;
        logic run1;
        logic full0;
        logic run0;
    } tdt_timer_control_reg_t;

endpackage

// file: verilog/tdt_edge_sync.sv
`timescale 1ns/100ps
module tdt_edge_sync #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // raw levels
    input  wire logic [W-1:0] async_in,
    // one-cycle edge pulses
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] last;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta[g] <= 1'b0;
                    sync[g] <= 1'b0;
                    last[g] <= 1'b0;
                end else begin
                    meta[g] <= async_in[g];
                    sync[g] <= meta[g];
                    last[g] <= sync[g];
                end
            end
            assign rise[g] = sync[g] & ~last[g];
            assign fall[g] = ~sync[g] & last[g];
        end
    endgenerate
endmodule

// file: verilog/tdt_divider.sv
`timescale 1ns/100ps
module tdt_divider #(
    parameter int DIV = 8
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // input events and divided events
    input  wire logic step,
    output logic      tick
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

    logic [W-1:0] cnt;
    wire          last = (cnt == W'(DIV - 1));

    assign tick = step & last;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (step) begin
            cnt <= last ? '0 : cnt + 1'b1;
        end
    end
endmodule

// file: verilog/tdt_timer.sv
// What this block does
// - three-bit field selects one of eight modes
// - mode 7 kept for firmware calibration
// - no interrupt; software polls full flags
// - clock select bits plus crystal enable pick clock
// - RC clock divided by 1,8,32,128,512
// - timer1 underflow can clock timer0; timer1 counts pin edges
// - 4.4kHz, crystal/6; timer0 crystal/512, 90kHz/8
// - registers load and read on system clock
// - single-run timer counts down once then halts
// - underflow one count after reaching zero
// - single-run underflow clears run, sets full
// - reloading timer reloads on underflow, keeps counting
// - full flag sticky until software clears it
// - reloading timer holds while run cleared, except timer1 in mode 3
// - mode 0: 16-bit reload, timer1 holds reload
// - mode 1: 16-bit single, 8-bit reload timer1
// - mode 2: two 8-bit reloading timers
// - mode 3: two 8-bit singles, timer1 reloads
// - mode 4: timer1 16-bit reload from timer0
// - modes 5,6: timer1 16-bit single-run
// - modes 1-3 timer1 gives baud rate
// - system clock divider field held in block
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
`include "tdt_defines.svh"
module tdt_timer (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // count clock sources
    input  wire logic        osc_2k2,
    input  wire logic        osc_90k,
    input  wire logic        xtal_clk,
    input  wire logic        port_pin_two,
    // outputs to the rest of the chip
    output logic      [2:0]  system_clock_divider,
    output logic             baud_tick
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic                timer_block_enable;
    logic                crystal_count_clock_enable;
    logic [2:0]          timer0_clock_select;
    logic [2:0]          timer1_clock_select;
    logic [2:0]          mode_select_bits;
    logic [7:0]          cnt      [4];
    logic [7:0]          next_cnt [4];
    tdt_pkg::tdt_timer_control_reg_t  timer_control_reg;
    tdt_pkg::tdt_timer_control_reg_t  next_timer_control_reg;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire        setup    = psel & ~penable;
    wire        access   = psel & penable & pready;
    wire [7:0]  cnt_base = {paddr[7:4], 4'h0};
    wire [1:0]  cidx     = paddr[3:2];
    wire        hit_ctrl = (paddr == `TDT_OFF_CTRL);
    wire        hit_mode = (paddr == `TDT_OFF_MODE);
    wire        hit_timer_control_reg = (paddr == `TDT_OFF_TIMER_CONTROL_REG);
    wire        hit_cnt  = (cnt_base == `TDT_OFF_CNT_BASE) & (paddr[1:0] == 2'h0);
    wire        hit_any  = hit_ctrl | hit_mode | hit_timer_control_reg | hit_cnt;
    wire        wr       = access & pwrite & pstrb[0] & ~pslverr;

    wire [31:0] ctrl_word = {24'h000000, timer1_clock_select, timer0_clock_select,
                             crystal_count_clock_enable, timer_block_enable};
    wire [31:0] mode_word = {25'h0000000, system_clock_divider, 1'b0, mode_select_bits};
    wire [31:0] timer_control_reg_word = {28'h0000000, timer_control_reg};
    wire [31:0] rd_data   = hit_ctrl ? ctrl_word :
                            hit_mode ? mode_word :
                            hit_timer_control_reg ? timer_control_reg_word :
                            hit_cnt  ? {24'h000000, cnt[cidx]} : 32'h00000000;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    wire m0 = (mode_select_bits == `TDT_MODE_0);
    wire m1 = (mode_select_bits == `TDT_MODE_1);
    wire m2 = (mode_select_bits == `TDT_MODE_2);
    wire m3 = (mode_select_bits == `TDT_MODE_3);
    wire m4 = (mode_select_bits == `TDT_MODE_4);
    wire m5 = (mode_select_bits == `TDT_MODE_5);
    wire m6 = (mode_select_bits == `TDT_MODE_6);
    wire m7 = (mode_select_bits == `TDT_MODE_7);

    // timer 0 role: 16-bit in modes 0,1,6,7; reloads in 0,2,5
    wire t0_wide   = m0 | m1 | m6 | m7;
    wire t0_reload = m0 | m2 | m5;
    // timer 1 role: 16-bit in modes 4..7; reloads in 1..4
    wire t1_wide   = m4 | m5 | m6 | m7;
    wire t1_reload = m1 | m2 | m3 | m4;
    // mode 3 lends run1 to the high byte of timer 0
    wire t1_act    = m3 | (~m0 & timer_control_reg.run1);
    wire t1_flag   = ~m0 & ~m3;

    wire [7:0]  l0 = cnt[`TDT_IDX_L0];
    wire [7:0]  h0 = cnt[`TDT_IDX_H0];
    wire [7:0]  l1 = cnt[`TDT_IDX_L1];
    wire [7:0]  h1 = cnt[`TDT_IDX_H1];
    wire [15:0] c0 = {h0, l0};
    wire [15:0] c1 = {h1, l1};

    // ------------------------------------------------------------
    // count clock sources
    // ------------------------------------------------------------
    logic [3:0] rise;
    logic [3:0] fall;
    logic [4:0] rc_tick;
    logic       x6;
    logic       x512;
    logic       r90_8;

    tdt_edge_sync #(.W(4)) u_sync (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in ({port_pin_two, xtal_clk, osc_90k, osc_2k2}),
        .rise     (rise),
        .fall     (fall)
    );

    // both edges of the 2.2 kHz clock give 4.4 kHz
    wire low_tick = rise[0] | fall[0];
    wire pin_rise = rise[3];

    localparam int RC_DIV [4] = '{`TDT_RC_DIV8, `TDT_RC_DIV32,
                                  `TDT_RC_DIV128, `TDT_RC_DIV512};
    assign rc_tick[0] = 1'b1;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_rc
            tdt_divider #(.DIV(RC_DIV[g])) u_rc (
                .clk   (pclk),
                .rst_n (presetn),
                .step  (1'b1),
                .tick  (rc_tick[g+1])
            );
        end
    endgenerate

    tdt_divider #(.DIV(`TDT_XT_DIV6)) u_x6 (
        .clk   (pclk),
        .rst_n (presetn),
        .step  (rise[2]),
        .tick  (x6)
    );
    tdt_divider #(.DIV(`TDT_XT_DIV512)) u_x512 (
        .clk   (pclk),
        .rst_n (presetn),
        .step  (rise[2]),
        .tick  (x512)
    );
    tdt_divider #(.DIV(`TDT_R90_DIV8)) u_r90 (
        .clk   (pclk),
        .rst_n (presetn),
        .step  (rise[1]),
        .tick  (r90_8)
    );

    // crystal enable switches timer 0 to crystal/6, crystal/512 and 90 kHz/8 sources, timer 1 to crystal/6 only
    function automatic logic pick(input logic [2:0] sel, input logic xsel,
                                  input logic [7:0] rcs, input logic [7:0] xs);
        pick = xsel ? xs[sel] : rcs[sel];
    endfunction

    function automatic tdt_pkg::tdt_step_t step(input logic [15:0] v, input logic [15:0] rel,
                                                input logic wide, input logic rld);
        tdt_pkg::tdt_step_t s;
        s.uf  = wide ? (v == 16'h0000) : (v[7:0] == 8'h00);
        s.val = s.uf ? (rld ? rel : v) : v - 16'h0001;
        return s;
    endfunction

    tdt_pkg::tdt_step_t s0;
    tdt_pkg::tdt_step_t s1;
    tdt_pkg::tdt_step_t sh;
    logic               uf1;

    wire tick1 = timer_block_enable & pick(timer1_clock_select, crystal_count_clock_enable,
                 {1'b0, pin_rise, low_tick, rc_tick}, {7'h00, x6});
    wire tick0 = timer_block_enable & pick(timer0_clock_select, crystal_count_clock_enable,
                 {1'b0, uf1, low_tick, rc_tick}, {5'h00, r90_8, x512, x6});

    // ------------------------------------------------------------
    // counter steps
    // ------------------------------------------------------------
    // underflow fires on the tick after zero is reached
    assign s0 = step(c0, t0_wide ? c1 : {8'h00, h0}, t0_wide, t0_reload);
    assign s1 = step(c1, t1_wide ? c0 : {8'h00, h1}, t1_wide, t1_reload);
    assign sh = step({8'h00, h0}, 16'h0000, 1'b0, 1'b0);

    wire t0_go = tick0 & timer_control_reg.run0 & ~m4;
    wire th_go = tick0 & timer_control_reg.run1 & m3;
    wire t1_go = tick1 & t1_act;
    wire uf0   = t0_go & s0.uf;
    wire ufh   = th_go & sh.uf;
    assign uf1 = t1_go & s1.uf;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_cnt[i] = cnt[i];
        end
        if (t0_go) begin
            next_cnt[`TDT_IDX_L0] = s0.val[7:0];
            if (t0_wide) begin
                next_cnt[`TDT_IDX_H0] = s0.val[15:8];
            end
        end
        if (th_go) begin
            next_cnt[`TDT_IDX_H0] = sh.val[7:0];
        end
        if (t1_go) begin
            next_cnt[`TDT_IDX_L1] = s1.val[7:0];
            if (t1_wide) begin
                next_cnt[`TDT_IDX_H1] = s1.val[15:8];
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (wr & hit_cnt & (cidx == 2'(i))) begin
                next_cnt[i] = pwdata[7:0];
            end
        end
    end

    always_comb begin
        next_timer_control_reg = timer_control_reg;
        if (uf0 & ~t0_reload) begin
            next_timer_control_reg.run0 = 1'b0;
        end
        if (ufh | (uf1 & ~t1_reload & t1_flag)) begin
            next_timer_control_reg.run1 = 1'b0;
        end
        if (wr & hit_timer_control_reg) begin
            next_timer_control_reg.run0  = pwdata[`TDT_TIMER_CONTROL_REG_RUN0];
            next_timer_control_reg.run1  = pwdata[`TDT_TIMER_CONTROL_REG_RUN1];
            next_timer_control_reg.full0 = pwdata[`TDT_TIMER_CONTROL_REG_FULL0];
            next_timer_control_reg.full1 = pwdata[`TDT_TIMER_CONTROL_REG_FULL1];
        end
        // hardware set wins over a software clear
        if (uf0) begin
            next_timer_control_reg.full0 = 1'b1;
        end
        if (ufh | (uf1 & t1_flag)) begin
            next_timer_control_reg.full1 = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= setup ? rd_data : prdata;
            pready  <= setup;
            pslverr <= setup & ~hit_any;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_block_enable         <= 1'b0;
            crystal_count_clock_enable <= 1'b0;
            timer0_clock_select        <= `TDT_RST_FLD;
            timer1_clock_select        <= `TDT_RST_FLD;
        end else if (wr & hit_ctrl) begin
            timer_block_enable         <= pwdata[`TDT_CTRL_EN];
            crystal_count_clock_enable <= pwdata[`TDT_CTRL_XEN];
            timer0_clock_select        <= pwdata[`TDT_CTRL_SEL0];
            timer1_clock_select        <= pwdata[`TDT_CTRL_SEL1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_select_bits     <= `TDT_RST_FLD;
            system_clock_divider <= `TDT_RST_FLD;
        end else if (wr & hit_mode) begin
            mode_select_bits     <= pwdata[`TDT_MODE_FLD];
            system_clock_divider <= pwdata[`TDT_MODE_DIV];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_reg      <= '0;
            baud_tick <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                cnt[i] <= `TDT_RST_BYTE;
            end
        end else begin
            timer_control_reg      <= next_timer_control_reg;
            baud_tick <= uf1 & (m1 | m2 | m3);
            for (int i = 0; i < 4; i++) begin
                cnt[i] <= next_cnt[i];
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_single_zero;
        m6 && t0_go && c0 == 16'h0000 && !wr;
    endsequence
    sequence s_single_one;
        m6 && t0_go && c0 == 16'h0001 && !wr && !timer_control_reg.full0;
    endsequence

    AST_SINGLE_STOP: assert property (s_single_zero |=> !timer_control_reg.run0 && timer_control_reg.full0)
        else $error("single-run underflow did not stop the timer");
    AST_ZERO_NO_UF: assert property (s_single_one |=> c0 == 16'h0000 && !timer_control_reg.full0)
        else $error("underflow flagged on the cycle zero was reached");
    AST_COUNT_DOWN: assert property (m6 && t0_go && c0 != 16'h0000 && !wr
                                     |=> c0 == $past(c0) - 16'h0001)
        else $error("single-run counter did not decrement");
    AST_RELOAD8: assert property (m2 && t0_go && l0 == 8'h00 && !wr
                                  |=> l0 == $past(h0) && timer_control_reg.run0 && timer_control_reg.full0)
        else $error("8-bit reload failed");
    AST_HOLD: assert property (m2 && !timer_control_reg.run0 && !wr |=> $stable(l0))
        else $error("stopped reloading timer changed");
    AST_FULL_STICKY: assert property (timer_control_reg.full0 && !(wr && hit_timer_control_reg) |=> timer_control_reg.full0)
        else $error("full flag cleared without software");
    AST_MODE0_RELOAD: assert property (m0 && !wr |=> $stable(c1))
        else $error("mode 0 reload registers changed");
    AST_MODE3_HIGH: assert property (m3 && th_go && h0 == 8'h00 && !wr
                                     |=> !timer_control_reg.run1 && timer_control_reg.full1)
        else $error("mode 3 high byte did not stop on underflow");
    AST_PRESCALE8: assert property (rc_tick[1] |=> !rc_tick[1] [*7] ##1 rc_tick[1])
        else $error("divide-by-8 tick period wrong");
    AST_APB_READY: assert property (setup |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
    AST_BAUD: assert property (uf1 && m2 |=> baud_tick)
        else $error("baud tick missing");
endmodule

// file: sim/tdt_timer_bench.sv
`timescale 1ns/100ps
`include "tdt_defines.svh"
module tdt_timer_bench;
    localparam logic [7:0] A_CT = `TDT_OFF_CTRL;
    localparam logic [7:0] A_MD = `TDT_OFF_MODE;
    localparam logic [7:0] A_TC = `TDT_OFF_TIMER_CONTROL_REG;
    localparam logic [7:0] A_L0 = `TDT_OFF_CNT_BASE;
    localparam logic [7:0] A_H0 = `TDT_OFF_CNT_BASE + 8'h04;
    localparam logic [7:0] A_L1 = `TDT_OFF_CNT_BASE + 8'h08;
    localparam logic [7:0] A_H1 = `TDT_OFF_CNT_BASE + 8'h0C;
    typedef struct {
        logic [7:0]  a;
        logic [31:0] wd;
        logic [31:0] rd;
        logic        er;
    } tdt_row_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        port_pin_two = 1'b0;
    // slow count sources from a free-running divider
    logic [5:0]  src_div = 6'h00;
    wire         xtal_clk = src_div[2];
    wire         osc_90k  = src_div[3];
    wire         osc_2k2  = src_div[5];
    logic [2:0]  system_clock_divider;
    logic        baud_tick;
    int          failures = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          bt_count = 0;
    logic [31:0] v;
    logic        e;
    tdt_row_t    rows[7];
    logic [31:0] prdata_hold;
    // run and full bits expected per mode 0 to 6
    logic [7:0]  mode_tc[7] = '{8'h07, 8'h0E, 8'h0F, 8'h0A, 8'h0D, 8'h0B, 8'h0A};
    logic [7:0]  src_ct[4]  = '{8'h03, 8'h07, 8'h0B, 8'h15};
    // ------------------------------------------------------------
    // design and clock
    // ------------------------------------------------------------
    tdt_timer i_tdt_timer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_2k2(osc_2k2), .osc_90k(osc_90k), .xtal_clk(xtal_clk),
        .port_pin_two(port_pin_two),
        .system_clock_divider(system_clock_divider), .baud_tick(baud_tick)
    );
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        src_div <= src_div + 6'h01;
        if (baud_tick === 1'b1) begin
            bt_count++;
        end
        if (cycles == 40000) begin
            failures++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // settled value ahead of the edge that samples it
        @(negedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
            @(negedge pclk);
        end
        rd = prdata;
        er = pslverr;
        @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        x;
        apb(1'b1, a, {24'h0, d}, r, x);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic x;
        apb(1'b0, a, 32'h0, d, x);
    endtask
    task automatic wait_full(input logic [31:0] m, input int lim);
        logic [31:0] t;
        int          k;
        t = 32'h0;
        for (k = 0; k < lim && (t & m) == 32'h0; k++) begin
            rd(A_TC, t);
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rows[0] = '{A_CT, 32'h1E6, 32'hE6, 1'b0};
        rows[1] = '{A_MD, 32'h53, 32'h53, 1'b0};
        rows[2] = '{A_L0, 32'hA5, 32'hA5, 1'b0};
        rows[3] = '{A_H0, 32'h5A, 32'h5A, 1'b0};
        rows[4] = '{A_L1, 32'h3C, 32'h3C, 1'b0};
        rows[5] = '{A_TC, 32'h0A, 32'h0A, 1'b0};
        rows[6] = '{8'h0C, 32'h55, 32'h00, 1'b1};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            rd(rows[i].a, v);
            check("reset value", v, 32'h0);
        end
        check("divider at reset", {29'h0, system_clock_divider}, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].wd, v, e);
            check("write error", {31'h0, e}, {31'h0, rows[i].er});
            apb(1'b0, rows[i].a, 32'h0, v, e);
            check("read back", v, rows[i].rd);
            check("read error", {31'h0, e}, {31'h0, rows[i].er});
        end
        check("divider output", {29'h0, system_clock_divider}, 32'h5);
        // disabled module holds its counter
        wr(A_CT, 8'h00);
        wr(A_MD, {5'h00, `TDT_MODE_2});
        wr(A_TC, 8'h00);
        wr(A_L0, 8'h09);
        wr(A_TC, 8'h01);
        repeat (50) @(posedge pclk);
        rd(A_L0, v);
        check("disabled count", v, 32'h09);
        // single-run 16-bit
        wr(A_CT, 8'h01);
        wr(A_MD, {5'h00, `TDT_MODE_6});
        wr(A_TC, 8'h00);
        wr(A_L0, 8'h05);
        wr(A_H0, 8'h00);
        wr(A_TC, 8'h01);
        wait_full(32'h2, 50);
        rd(A_TC, v);
        check("single-run timer_control_reg", v, 32'h02);
        rd(A_L0, v);
        check("single-run halt", v, 32'h00);
        repeat (30) @(posedge pclk);
        rd(A_TC, v);
        check("full sticky", v, 32'h02);
        // 8-bit reload on slow prescaler
        wr(A_CT, 8'h11);
        wr(A_MD, {5'h00, `TDT_MODE_2});
        wr(A_TC, 8'h00);
        wr(A_L0, 8'h01);
        wr(A_H0, 8'h07);
        wr(A_TC, 8'h01);
        wait_full(32'h2, 800);
        rd(A_L0, v);
        check("8-bit reload", {31'h0, v == 32'h07 || v == 32'h06}, 32'h1);
        rd(A_TC, v);
        check("reload run kept", v, 32'h03);
        wr(A_TC, 8'h00);
        rd(A_L0, v);
        repeat (1100) @(posedge pclk);
        apb(1'b0, A_L0, 32'h0, prdata_hold, e);
        check("held while stopped", prdata_hold, v);
        // 16-bit reload from timer 1 registers
        wr(A_MD, {5'h00, `TDT_MODE_0});
        wr(A_L0, 8'h01);
        wr(A_H0, 8'h00);
        wr(A_L1, 8'h00);
        wr(A_H1, 8'h02);
        wr(A_TC, 8'h01);
        wait_full(32'h2, 800);
        rd(A_H0, v);
        check("16-bit reload high", {31'h0, v == 32'h02 || v == 32'h01}, 32'h1);
        // timer 1 counts pin rising edges
        wr(A_TC, 8'h00);
        wr(A_CT, 8'hC1);
        wr(A_MD, {5'h00, `TDT_MODE_6});
        wr(A_L1, 8'h05);
        wr(A_H1, 8'h00);
        wr(A_TC, 8'h04);
        for (int i = 0; i < 3; i++) begin
            repeat (6) @(posedge pclk);
            port_pin_two <= 1'b1;
            repeat (6) @(posedge pclk);
            port_pin_two <= 1'b0;
        end
        repeat (10) @(posedge pclk);
        rd(A_L1, v);
        check("pin edge count", v, 32'h02);
        // baud pulses only in modes 1 to 3
        wr(A_CT, 8'h01);
        wr(A_MD, {5'h00, `TDT_MODE_2});
        wr(A_L1, 8'h02);
        wr(A_H1, 8'h02);
        wr(A_TC, 8'h04);
        bt_count = 0;
        repeat (100) @(posedge pclk);
        check("baud in mode 2", {31'h0, bt_count > 0}, 32'h1);
        wr(A_TC, 8'h00);
        wr(A_MD, {5'h00, `TDT_MODE_6});
        wr(A_L1, 8'h03);
        wr(A_H1, 8'h00);
        wr(A_TC, 8'h04);
        bt_count = 0;
        repeat (100) @(posedge pclk);
        check("baud in mode 6", bt_count, 32'h0);
        rd(A_TC, v);
        check("mode 6 timer 1 single", v, 32'h08);
        // every application mode, both timers at count one
        wr(A_CT, 8'h01);
        foreach (mode_tc[i]) begin
            wr(A_TC, 8'h00);
            wr(A_MD, 8'(i));
            wr(A_L0, 8'h01);
            wr(A_H0, 8'h00);
            wr(A_L1, 8'h01);
            wr(A_H1, 8'h00);
            bt_count = 0;
            wr(A_TC, 8'h05);
            repeat (20) @(posedge pclk);
            rd(A_TC, v);
            check("flags per mode", v, {24'h0, mode_tc[i]});
            check("baud per mode", {31'h0, bt_count > 0}, {31'h0, i >= 1 && i <= 3});
        end
        // crystal and slow sources each clock timer 0
        wr(A_MD, {5'h00, `TDT_MODE_6});
        foreach (src_ct[i]) begin
            wr(A_TC, 8'h00);
            wr(A_CT, src_ct[i]);
            wr(A_L0, 8'h00);
            wr(A_H0, 8'h00);
            wr(A_TC, 8'h01);
            wait_full(32'h2, 1500);
            rd(A_TC, v);
            check("source tick", v, 32'h02);
        end
        // write without byte strobe is ignored
        pstrb <= 4'h0;
        wr(A_L0, 8'h33);
        pstrb <= 4'hF;
        rd(A_L0, v);
        check("write without strobe", v, 32'h00);
        wr(A_CT, 8'h00);
        report_and_stop();
    end
endmodule
